// ==== rtl/dpc_pkg.sv ====
// Parameter map, defaults and carrier types of the drive parameter bank
package dpc_pkg;
	// Fieldbus parameter addresses
	localparam logic [15:0] ADDR_SAVE = 16'h0402;
	localparam logic [15:0] ADDR_CTRL_RST = 16'h040e;
	localparam logic [15:0] ADDR_USER_RST = 16'h0410;
	localparam logic [15:0] ADDR_RESTORE = 16'h0412;
	localparam logic [15:0] ADDR_HALT_LEVEL = 16'h1014;
	localparam logic [15:0] ADDR_DIVISOR = 16'h060e;
	localparam logic [15:0] ADDR_MULTIPLIER = 16'h0610;
	localparam logic [15:0] ADDR_TURN_SENSE = 16'h0618;

	// Field positions and command codes
	localparam int SAVE_BIT = 0;
	localparam int SIGN_BIT = 31;
	localparam logic [15:0] CTRL_RESET_CODE = 16'h0001;
	localparam logic [15:0] CMD_BUSY_VALUE = 16'h0001;

	// Reset and default values
	localparam logic [31:0] DIVISOR_RST = 32'h00004000;
	localparam logic [31:0] MULTIPLIER_RST = 32'h00000001;
	localparam logic [31:0] SCALE_MIN = 32'h00000001;
	localparam logic [31:0] SCALE_MAX = 32'h7fffffff;
	localparam logic DIR_CW = 1'b0;
	localparam logic DIR_CCW = 1'b1;
	localparam logic TURN_SENSE_RST = DIR_CW;
	localparam logic [15:0] HALT_LEVEL_RST = 16'h0000;

	// Non-volatile store sequencer, Gray coded along idle-save-restore
	typedef enum logic [1:0] {
		DPC_NV_IDLE = 2'b00,
		DPC_NV_SAVING = 2'b01,
		DPC_NV_RESTORING = 2'b11
	} dpc_nv_state_t;

	// One parameter access from the fieldbus side
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} dpc_param_req_t;

	// Answer to a parameter access
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} dpc_param_rsp_t;
endpackage : dpc_pkg

// ==== rtl/dpc_param_bank.sv ====
// Drive parameter bank: commands, scaling, rotation sense and undervoltage halt
`timescale 1ns/1ps
`default_nettype none
module dpc_param_bank
	import dpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire dpc_param_req_t param_req,
	output dpc_param_rsp_t param_rsp,
	input wire logic [15:0] dc_bus_voltage,
	input wire logic [15:0] halt_level_in,
	output logic quick_stop_q,
	input wire logic [31:0] cmd_speed,
	output logic shaft_ccw_q,
	output logic turn_sense_active_q,
	output logic [31:0] scale_multiplier_active_q,
	output logic [31:0] scale_divisor_active_q,
	output logic limits_refresh_q,
	output logic ctrl_defaults_q,
	output logic current_autotune_q,
	output logic user_reset_q,
	output logic factory_defaults_q,
	output logic nv_store_req_q,
	input wire logic nv_store_done
);

	// Addresses that answer reads without error
	function automatic logic is_mapped(input logic [15:0] a);
		case (a)
			ADDR_SAVE, ADDR_CTRL_RST, ADDR_USER_RST, ADDR_RESTORE,
			ADDR_HALT_LEVEL, ADDR_DIVISOR, ADDR_MULTIPLIER, ADDR_TURN_SENSE: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
		endcase
	endfunction : is_mapped

	// Positive signed 32-bit value inside the scaling range
	function automatic logic scale_ok(input logic [31:0] v);
		scale_ok = !v[SIGN_BIT] && (v >= SCALE_MIN) && (v <= SCALE_MAX);
	endfunction : scale_ok

	function automatic logic wr_to(input dpc_param_req_t r, input logic [15:0] a);
		wr_to = r.wr && (r.addr == a);
	endfunction : wr_to

	dpc_nv_state_t nv_state_q;
	logic [15:0] halt_level_q;
	logic turn_sense_q;
	logic started_q;
	logic [31:0] divisor_q;
	logic [31:0] multiplier_q;

	logic wr_save;
	logic wr_restore;
	logic wr_ctrl;
	logic wr_user;
	logic wr_div;
	logic wr_mul;
	logic wr_dir;
	logic nv_idle;

	assign nv_idle = (nv_state_q == DPC_NV_IDLE);
	assign wr_save = wr_to(param_req, ADDR_SAVE) && param_req.wdata[SAVE_BIT];
	assign wr_restore = wr_to(param_req, ADDR_RESTORE) && (param_req.wdata[15:0] != 16'h0000);
	assign wr_ctrl = wr_to(param_req, ADDR_CTRL_RST) && (param_req.wdata[15:0] == CTRL_RESET_CODE);
	assign wr_user = wr_to(param_req, ADDR_USER_RST) && (param_req.wdata[15:0] != 16'h0000);
	assign wr_div = wr_to(param_req, ADDR_DIVISOR) && scale_ok(param_req.wdata);
	assign wr_mul = wr_to(param_req, ADDR_MULTIPLIER) && scale_ok(param_req.wdata);
	assign wr_dir = wr_to(param_req, ADDR_TURN_SENSE);

	// Halt level arrives from the power stage; compared on this clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			halt_level_q <= HALT_LEVEL_RST;
			quick_stop_q <= 1'b0;
		end else begin
			halt_level_q <= halt_level_in;
			quick_stop_q <= (dc_bus_voltage <= halt_level_q);
		end
	end

	// Store sequencer; a second request while busy is dropped, not queued
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nv_state_q <= DPC_NV_IDLE;
			nv_store_req_q <= 1'b0;
		end else begin
			nv_store_req_q <= 1'b0;
			case (nv_state_q)
				DPC_NV_IDLE: begin
					if (wr_restore) begin
						nv_state_q <= DPC_NV_RESTORING;
						nv_store_req_q <= 1'b1;
					end else if (wr_save) begin
						nv_state_q <= DPC_NV_SAVING;
						nv_store_req_q <= 1'b1;
					end
				end
				DPC_NV_SAVING, DPC_NV_RESTORING: begin
					if (nv_store_done) begin
						nv_state_q <= DPC_NV_IDLE;
					end
				end
				default: begin
					nv_state_q <= DPC_NV_IDLE;
				end
			endcase
		end
	end

	// Command pulses towards the control loops; user reset starts no store
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_defaults_q <= 1'b0;
			current_autotune_q <= 1'b0;
			user_reset_q <= 1'b0;
			factory_defaults_q <= 1'b0;
		end else begin
			ctrl_defaults_q <= wr_ctrl;
			current_autotune_q <= wr_ctrl;
			user_reset_q <= wr_user;
			factory_defaults_q <= wr_restore && nv_idle;
		end
	end

	// On restore, defaults are loaded in the same edge the store starts, so it stores them
	logic load_defaults;
	assign load_defaults = (wr_restore && nv_idle) || wr_user;

	// Turn sense is stored now, applied only in the first cycle after reset, while turn_sense_q still holds TURN_SENSE_RST
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			turn_sense_q <= TURN_SENSE_RST;
			turn_sense_active_q <= TURN_SENSE_RST;
			started_q <= 1'b0;
		end else begin
			if (load_defaults) begin
				turn_sense_q <= TURN_SENSE_RST;
			end else if (wr_dir) begin
				turn_sense_q <= param_req.wdata[0] ? DIR_CCW : DIR_CW;
			end
			if (!started_q) begin
				turn_sense_active_q <= turn_sense_q;
				started_q <= 1'b1;
			end
		end
	end

	// Negative speed or counterclockwise sense, but not both, reverses the shaft
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shaft_ccw_q <= DIR_CW;
		end else begin
			shaft_ccw_q <= turn_sense_active_q ^ cmd_speed[SIGN_BIT];
		end
	end

	// Out-of-range scaling writes are refused and flagged as errors
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divisor_q <= DIVISOR_RST;
			multiplier_q <= MULTIPLIER_RST;
			scale_divisor_active_q <= DIVISOR_RST;
			scale_multiplier_active_q <= MULTIPLIER_RST;
			limits_refresh_q <= 1'b0;
		end else begin
			limits_refresh_q <= 1'b0;
			if (load_defaults) begin
				divisor_q <= DIVISOR_RST;
				multiplier_q <= MULTIPLIER_RST;
				scale_divisor_active_q <= DIVISOR_RST;
				scale_multiplier_active_q <= MULTIPLIER_RST;
				limits_refresh_q <= 1'b1;
			end else begin
				if (wr_div) begin
					divisor_q <= param_req.wdata;
				end
				if (wr_mul) begin
					multiplier_q <= param_req.wdata;
					scale_multiplier_active_q <= param_req.wdata;
					scale_divisor_active_q <= divisor_q;
					limits_refresh_q <= 1'b1;
				end
			end
		end
	end

	// Read mux; command parameters read nonzero while their store runs
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h00000000;
		case (param_req.addr)
			ADDR_SAVE: begin
				rd_val[15:0] = (nv_state_q == DPC_NV_SAVING) ? CMD_BUSY_VALUE : 16'h0000;
			end
			ADDR_RESTORE: begin
				rd_val[15:0] = (nv_state_q == DPC_NV_RESTORING) ? CMD_BUSY_VALUE : 16'h0000;
			end
			ADDR_HALT_LEVEL: begin
				rd_val[15:0] = halt_level_q;
			end
			ADDR_DIVISOR: begin
				rd_val = divisor_q;
			end
			ADDR_MULTIPLIER: begin
				rd_val = multiplier_q;
			end
			ADDR_TURN_SENSE: begin
				rd_val[0] = turn_sense_q;
			end
			default: begin
				rd_val = 32'h00000000;
			end
		endcase
	end

	logic bad_write;
	assign bad_write = param_req.wr && (param_req.addr == ADDR_HALT_LEVEL ||
		((param_req.addr == ADDR_DIVISOR || param_req.addr == ADDR_MULTIPLIER) &&
		!scale_ok(param_req.wdata)));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			param_rsp <= '0;
		end else begin
			param_rsp.ack <= param_req.wr || param_req.rd;
			param_rsp.err <= (param_req.wr || param_req.rd) &&
				(!is_mapped(param_req.addr) || bad_write);
			param_rsp.rdata <= param_req.rd ? rd_val : 32'h00000000;
		end
	end

	undervolt_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
		##2 quick_stop_q == ($past(dc_bus_voltage) <= $past(halt_level_in, 2)))
		else $error("quick stop does not follow bus voltage against halt level");

	ctrl_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_ctrl |=> ctrl_defaults_q && current_autotune_q ##1 (!ctrl_defaults_q || $past(wr_ctrl)))
		else $error("controller reset pulse missing or too long");

	autotune_pair_a: assert property (@(posedge sys_clk) disable iff (rst)
		current_autotune_q == ctrl_defaults_q)
		else $error("current loop retune not paired with controller reset");

	save_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		(nv_idle && wr_save && !wr_restore) |=> nv_store_req_q && nv_state_q == DPC_NV_SAVING ##1
		!nv_store_req_q)
		else $error("save write did not start a single store request");

	save_busy_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		(param_req.rd && param_req.addr == ADDR_SAVE && nv_state_q == DPC_NV_SAVING)
		|=> param_rsp.ack && param_rsp.rdata != 32'h00000000)
		else $error("save command read zero while store still running");

	save_done_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!nv_idle && nv_store_done) |=> nv_idle)
		else $error("store completion did not return sequencer to idle");

	restore_defaults_a: assert property (@(posedge sys_clk) disable iff (rst)
		(nv_idle && wr_restore) |=> nv_store_req_q && divisor_q == DIVISOR_RST &&
		multiplier_q == MULTIPLIER_RST && turn_sense_q == DIR_CW)
		else $error("factory restore did not load defaults before storing");

	user_no_store_a: assert property (@(posedge sys_clk) disable iff (rst)
		(nv_idle && wr_user && !wr_save && !wr_restore) |=> !nv_store_req_q && nv_idle)
		else $error("user settings reset started a store");

	sense_frozen_a: assert property (@(posedge sys_clk) disable iff (rst)
		started_q |=> $stable(turn_sense_active_q))
		else $error("turn sense changed without power cycle");

	shaft_sense_a: assert property (@(posedge sys_clk) disable iff (rst)
		(started_q && turn_sense_active_q == DIR_CW && !cmd_speed[SIGN_BIT]) |=> !shaft_ccw_q)
		else $error("positive speed not clockwise with clockwise sense");

	divisor_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!wr_mul && !load_defaults) |=> $stable(scale_divisor_active_q))
		else $error("scaling applied without multiplier write");

	scale_range_a: assert property (@(posedge sys_clk) disable iff (rst)
		scale_ok(divisor_q) && scale_ok(multiplier_q))
		else $error("scaling value outside 1 to 2147483647");

	busy_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
		(nv_state_q == DPC_NV_SAVING && !nv_store_done) |=> nv_state_q == DPC_NV_SAVING)
		else $error("store state disturbed before completion");

endmodule : dpc_param_bank
`default_nettype wire

// ==== verification/dpc_nv_store_model.sv ====
// Non-volatile store stand-in that finishes each store after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module dpc_nv_store_model #(
	parameter int LATENCY = 6
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic nv_store_req_q,
	output logic nv_store_done
);
	int cnt_q;
	// Slow enough that the bench can poll the busy value several times
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= 0;
		end else if (nv_store_req_q) begin
			cnt_q <= LATENCY;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
	assign nv_store_done = (cnt_q == 1);
endmodule : dpc_nv_store_model
`default_nettype wire

// ==== verification/dpc_param_bank_tb.sv ====
// Self-checking bench for the drive parameter bank
`timescale 1ns/1ps
`default_nettype none
module dpc_param_bank_tb import dpc_pkg::*;;
	logic sys_clk, rst, nv_done, qs, ccw, sense_a, lim, ctl, tune, usr, fact, nvr, e;
	dpc_param_req_t req;
	dpc_param_rsp_t rsp;
	logic [15:0] dc_v, halt_lv;
	logic [31:0] speed, mul_a, div_a, q;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	int n_lim = 0, n_ctl = 0, n_tune = 0, n_usr = 0, n_fact = 0, n_nv = 0;

	dpc_param_bank DUT (.sys_clk(sys_clk), .rst(rst), .param_req(req), .param_rsp(rsp),
		.dc_bus_voltage(dc_v), .halt_level_in(halt_lv), .quick_stop_q(qs), .cmd_speed(speed),
		.shaft_ccw_q(ccw), .turn_sense_active_q(sense_a), .scale_multiplier_active_q(mul_a),
		.scale_divisor_active_q(div_a), .limits_refresh_q(lim), .ctrl_defaults_q(ctl),
		.current_autotune_q(tune), .user_reset_q(usr), .factory_defaults_q(fact),
		.nv_store_req_q(nvr), .nv_store_done(nv_done));
	dpc_nv_store_model store (.sys_clk(sys_clk), .rst(rst), .nv_store_req_q(nvr),
		.nv_store_done(nv_done));

	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	// Pulses are counted so that tests need not hit their exact cycle
	always @(posedge sys_clk) begin
		cyc++;
		if (!rst) begin
			n_lim += int'(lim);
			n_ctl += int'(ctl);
			n_tune += int'(tune);
			n_usr += int'(usr);
			n_fact += int'(fact);
			n_nv += int'(nvr);
		end
		if (cyc == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			n_mismatch++;
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		tick(1);
		// Answer stands only in the cycle after the strobe, so take it now
		req = '0;
		check("ack", 32'(rsp.ack), 32'h1);
		q = rsp.rdata;
		e = rsp.err;
		tick(1);
	endtask : acc

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic err);
		acc(1'b1, a, d);
		check("err", 32'(e), 32'(err));
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		check("rdata", q, exp);
	endtask : rd

	task automatic poll(input logic [15:0] a);
		q = 32'h1;
		for (int i = 0; i < 40 && q !== 32'h0; i++) begin
			acc(1'b0, a, 32'h0);
		end
		check("poll", q, 32'h0);
	endtask : poll

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		rst = 1'b1;
		req = '0;
		dc_v = 16'h0200;
		halt_lv = 16'h0100;
		speed = 32'h00000010;
		tick(4);
		rst = 1'b0;
		tick(1);
		check("div_a", div_a, 32'h4000);
		check("mul_a", mul_a, 32'h1);
		rd(ADDR_TURN_SENSE, 32'h0);
		check("ccw", 32'(ccw), 32'h0);
		speed = 32'hfffffff0;
		tick(2);
		check("ccw", 32'(ccw), 32'h1);
		rd(ADDR_HALT_LEVEL, 32'h0100);
		wr(ADDR_HALT_LEVEL, 32'h0, 1'b1);
		check("qs", 32'(qs), 32'h0);
		dc_v = 16'h0100;
		tick(2);
		check("qs", 32'(qs), 32'h1);
		halt_lv = 16'h00ff;
		tick(3);
		check("qs", 32'(qs), 32'h0);
		wr(ADDR_DIVISOR, 32'h3, 1'b0);
		check("div_a", div_a, 32'h4000);
		wr(ADDR_MULTIPLIER, 32'h7, 1'b0);
		check("div_a", div_a, 32'h3);
		check("mul_a", mul_a, 32'h7);
		wr(ADDR_DIVISOR, 32'h0, 1'b1);
		wr(ADDR_DIVISOR, 32'h80000000, 1'b1);
		wr(ADDR_MULTIPLIER, 32'h0, 1'b1);
		wr(ADDR_MULTIPLIER, 32'h80000000, 1'b1);
		wr(ADDR_DIVISOR, 32'h7fffffff, 1'b0);
		rd(ADDR_DIVISOR, 32'h7fffffff);
		check("mul_a", mul_a, 32'h7);
		check("n_lim", 32'(n_lim), 32'h1);
		wr(ADDR_CTRL_RST, 32'h2, 1'b0);
		wr(ADDR_CTRL_RST, 32'h1, 1'b0);
		tick(1);
		check("n_ctl", 32'(n_ctl), 32'h1);
		check("n_tune", 32'(n_tune), 32'h1);
		wr(ADDR_USER_RST, 32'h1, 1'b0);
		tick(1);
		check("n_usr", 32'(n_usr), 32'h1);
		check("n_nv", 32'(n_nv), 32'h0);
		check("div_a", div_a, 32'h4000);
		wr(ADDR_SAVE, 32'h1, 1'b0);
		rd(ADDR_SAVE, 32'(CMD_BUSY_VALUE));
		wr(ADDR_DIVISOR, 32'h5, 1'b0);
		wr(ADDR_SAVE, 32'h1, 1'b0);
		poll(ADDR_SAVE);
		rd(ADDR_DIVISOR, 32'h5);
		wr(ADDR_SAVE, 32'h2, 1'b0);
		tick(1);
		check("n_nv", 32'(n_nv), 32'h1);
		wr(ADDR_RESTORE, 32'h1, 1'b0);
		rd(ADDR_RESTORE, 32'(CMD_BUSY_VALUE));
		poll(ADDR_RESTORE);
		check("n_fact", 32'(n_fact), 32'h1);
		check("n_nv", 32'(n_nv), 32'h2);
		rd(ADDR_DIVISOR, 32'h4000);
		acc(1'b0, 16'h0000, 32'h0);
		check("err", 32'(e), 32'h1);
		wr(ADDR_TURN_SENSE, 32'h1, 1'b0);
		rd(ADDR_TURN_SENSE, 32'h1);
		tick(2);
		check("sense_a", 32'(sense_a), 32'h0);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(2);
		check("mul_a", mul_a, 32'h1);
		wrap_up();
	end
endmodule : dpc_param_bank_tb
`default_nettype wire
